/* rtl/spi_pkg.sv */
package spi_pkg;

    // register indices on the local register port
    localparam logic [2:0] OFS_STATUS_CONTROL = 3'h0;
    localparam logic [2:0] OFS_CONTROL_PRIMARY = 3'h1;
    localparam logic [2:0] OFS_CONTROL_FRAMING = 3'h2;
    localparam logic [2:0] OFS_DATA_BUFFER = 3'h3;
    localparam logic [2:0] OFS_EVENT_STATUS = 3'h4;
    localparam logic [2:0] OFS_EVENT_MASK = 3'h5;

    // status and control fields
    localparam int STAT_PORT_ENABLE = 15;
    localparam int STAT_HALT_IN_IDLE = 13;
    localparam int STAT_RX_OVERFLOW = 6;
    localparam int STAT_TX_FULL = 1;
    localparam int STAT_RX_FULL = 0;

    // primary control fields
    localparam int CP_INT_CLK_DISABLE = 12;
    localparam int CP_DATA_OUT_DISABLE = 11;
    localparam int CP_WORD_WIDTH = 10;
    localparam int CP_SAMPLE_PHASE = 9;
    localparam int CP_CLOCK_EDGE = 8;
    localparam int CP_SELECT_ENABLE = 7;
    localparam int CP_CLOCK_POLARITY = 6;
    localparam int CP_MASTER_ENABLE = 5;
    localparam int CP_SEC_PRESCALE_LSB = 2;
    localparam int CP_PRI_PRESCALE_LSB = 0;

    // framing control fields
    localparam int CF_FRAMED_ENABLE = 15;
    localparam int CF_SYNC_DIRECTION = 14;
    localparam int CF_SYNC_POLARITY = 13;
    localparam int CF_SYNC_EDGE = 1;

    // reset values and writable bits
    localparam logic [15:0] RESET_VALUE = 16'h0000;
    localparam logic [15:0] PRIMARY_WMASK = 16'h1FFF;
    localparam logic [15:0] FRAMING_WMASK = 16'hE002;

    // event bits: receive done, transmit value taken, overflow
    localparam int EV_RX_DONE = 0;
    localparam int EV_TX_TAKEN = 1;
    localparam int EV_OVERFLOW = 2;
    localparam int EV_COUNT = 3;

    // prescaler ratios and transfer counts
    localparam logic [6:0] PRI_RATIO_64 = 7'h40;
    localparam logic [6:0] PRI_RATIO_16 = 7'h10;
    localparam logic [6:0] PRI_RATIO_4 = 7'h04;
    localparam logic [6:0] PRI_RATIO_1 = 7'h01;
    localparam logic [3:0] SEC_RATIO_MAX = 4'h8;
    localparam logic [5:0] BYTE_BITS = 6'h08;
    localparam logic [5:0] WORD_BITS = 6'h10;
    localparam logic [5:0] FRAME_LEAD_TICKS = 6'h02;
    localparam int SYNC_WIDTH = 3;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } xfer_state_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic shift_clock_out;
        logic shift_clock_oe_n;
        logic serial_out;
        logic serial_out_oe_n;
        logic select_out;
        logic select_oe_n;
    } pin_out_t;

endpackage

/* rtl/input_sync.sv */
module input_sync
    import spi_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // asynchronous inputs and their synchronised copies
    input wire logic [SYNC_WIDTH-1:0] async_in,
    output logic [SYNC_WIDTH-1:0] sync_out
);

    // two flops per pin; the first is read only by the second
    genvar i;
    generate
        for (i = 0; i < SYNC_WIDTH; i++) begin : g_bit
            logic meta_q;
            logic hold_q;
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    meta_q <= 1'b0;
                    hold_q <= 1'b0;
                end else begin
                    meta_q <= async_in[i];
                    hold_q <= meta_q;
                end
            end
            assign sync_out[i] = hold_q;
        end
    endgenerate

endmodule // input_sync

/* rtl/spi_serial_port_unit.sv */
// How it works
// - one 16-bit shift register; software sees only the buffer registers.
// - master drives the shift clock pin unless the internal clock is disabled; slave takes it as input.
// - select pin low selects the slave when select use is enabled.
// - new value while buffer unread is dropped and overflow set.
// - buffer write sets transmit-full; loading the shift register clears it.
// - finished transfer sets receive-full; reading the buffer clears it.
// - width select picks 16-bit or 8-bit transfers.
// - framed mode turns the select pin into a frame sync line.
// - sync direction set receives the pulse, clear generates it.
module spi_serial_port_unit
    import spi_pkg::*;
(
    // system
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire bus_req_t bus_req,
    output logic [15:0] rd_data,
    // serial pins
    input wire logic shift_clock_pin,
    input wire logic serial_in_pin,
    input wire logic select_pin,
    output pin_out_t pins,
    // core power state
    input wire logic core_idle,
    // interrupt
    output logic irq
);

    // registers
    logic port_enable_q;
    logic halt_in_idle_q;
    logic receive_overflow_flag_q;
    logic transmit_buffer_full_q;
    logic receive_buffer_full_q;
    logic [15:0] ctrl_primary_q;
    logic [15:0] ctrl_framing_q;
    logic [15:0] transmit_holding_buffer_q;
    logic [15:0] receive_holding_buffer_q;
    logic [15:0] shift_register_q;
    logic [EV_COUNT-1:0] ev_status_q;
    logic [EV_COUNT-1:0] ev_mask_q;
    logic [15:0] rd_data_q;
    pin_out_t pins_q;
    xfer_state_t state_q;
    xfer_state_t state_d;
    logic [5:0] idx_q;
    logic [8:0] div_q;
    logic latch_q;
    logic clk_level_q;
    logic clk_prev_q;

    // register strobes
    logic wr_stat;
    logic wr_prim;
    logic wr_frm;
    logic wr_buf;
    logic wr_evs;
    logic wr_evm;
    logic rd_buf;
    assign wr_stat = bus_req.wr && bus_req.addr == OFS_STATUS_CONTROL;
    assign wr_prim = bus_req.wr && bus_req.addr == OFS_CONTROL_PRIMARY;
    assign wr_frm = bus_req.wr && bus_req.addr == OFS_CONTROL_FRAMING;
    assign wr_buf = bus_req.wr && bus_req.addr == OFS_DATA_BUFFER;
    assign wr_evs = bus_req.wr && bus_req.addr == OFS_EVENT_STATUS;
    assign wr_evm = bus_req.wr && bus_req.addr == OFS_EVENT_MASK;
    assign rd_buf = bus_req.rd && bus_req.addr == OFS_DATA_BUFFER;

    // configuration fields
    logic internal_clock_disable;
    logic data_out_pin_disable;
    logic word_width_select;
    logic sample_phase_select;
    logic clock_edge_select;
    logic slave_select_enable;
    logic clock_polarity_select;
    logic master_enable;
    logic [2:0] secondary_prescale;
    logic [1:0] primary_prescale;
    logic framed_mode_enable;
    logic frame_sync_direction;
    logic frame_sync_polarity;
    logic frame_sync_edge_select;
    assign internal_clock_disable = ctrl_primary_q[CP_INT_CLK_DISABLE];
    assign data_out_pin_disable = ctrl_primary_q[CP_DATA_OUT_DISABLE];
    assign word_width_select = ctrl_primary_q[CP_WORD_WIDTH];
    assign sample_phase_select = ctrl_primary_q[CP_SAMPLE_PHASE];
    assign clock_edge_select = ctrl_primary_q[CP_CLOCK_EDGE];
    assign slave_select_enable = ctrl_primary_q[CP_SELECT_ENABLE];
    assign clock_polarity_select = ctrl_primary_q[CP_CLOCK_POLARITY];
    assign master_enable = ctrl_primary_q[CP_MASTER_ENABLE];
    assign secondary_prescale = ctrl_primary_q[CP_SEC_PRESCALE_LSB +: 3];
    assign primary_prescale = ctrl_primary_q[CP_PRI_PRESCALE_LSB +: 2];
    assign framed_mode_enable = ctrl_framing_q[CF_FRAMED_ENABLE];
    assign frame_sync_direction = ctrl_framing_q[CF_SYNC_DIRECTION];
    assign frame_sync_polarity = ctrl_framing_q[CF_SYNC_POLARITY];
    assign frame_sync_edge_select = ctrl_framing_q[CF_SYNC_EDGE];

    // pin synchronisers: clock, data in, select
    logic [SYNC_WIDTH-1:0] pin_s;
    logic clk_s;
    logic din_s;
    logic sel_s;
    input_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in({select_pin, serial_in_pin, shift_clock_pin}),
        .sync_out(pin_s)
    );
    assign clk_s = pin_s[0];
    assign din_s = pin_s[1];
    assign sel_s = pin_s[2];

    // mode decode; sample phase only counts in master mode
    logic active;
    logic is_master;
    logic gen_frame;
    logic smp_eff;
    logic [5:0] nbits;
    logic [5:0] lead;
    logic [5:0] total;
    assign active = port_enable_q && !(halt_in_idle_q && core_idle);
    assign is_master = master_enable;
    assign gen_frame = framed_mode_enable && !frame_sync_direction;
    assign smp_eff = sample_phase_select && is_master;
    assign nbits = word_width_select ? WORD_BITS : BYTE_BITS;
    // a preceding pulse takes one whole bit time before the data
    assign lead = (framed_mode_enable && !frame_sync_edge_select) ?
        FRAME_LEAD_TICKS : 6'h00;
    // end-of-time sampling needs one half period more when edge bit is 0
    assign total = 6'((nbits << 1) + {5'h00, smp_eff && !clock_edge_select});

    // prescaler: one half period is half the combined ratio
    logic [6:0] pri_ratio;
    logic [3:0] sec_ratio;
    logic [10:0] ratio;
    logic [8:0] half_m1;
    always_comb begin
        case (primary_prescale)
            2'h0: pri_ratio = PRI_RATIO_64;
            2'h1: pri_ratio = PRI_RATIO_16;
            2'h2: pri_ratio = PRI_RATIO_4;
            default: pri_ratio = PRI_RATIO_1;
        endcase
    end
    assign sec_ratio = SEC_RATIO_MAX - {1'b0, secondary_prescale};
    assign ratio = 11'(pri_ratio * sec_ratio);
    assign half_m1 = (ratio[9:1] == 9'h000) ? 9'h000 : ratio[9:1] - 9'h001;

    // tick sources: divider in master, pin edges in slave
    logic div_tick;
    logic clk_edge;
    logic lead_edge;
    logic frame_in;
    logic slave_ok;
    logic abort;
    logic tick;
    assign div_tick = state_q == ST_RUN && div_q == half_m1;
    assign clk_edge = clk_s != clk_prev_q;
    assign lead_edge = clk_s != clock_polarity_select;
    assign frame_in = sel_s == frame_sync_polarity;
    always_comb begin
        if (framed_mode_enable)
            slave_ok = state_q == ST_RUN || frame_in;
        else if (slave_select_enable)
            slave_ok = !sel_s;
        else
            slave_ok = 1'b1;
    end
    // deselect in the middle of a slave transfer drops it
    assign abort = state_q == ST_RUN && !is_master && !framed_mode_enable &&
        slave_select_enable && sel_s;
    assign tick = active && !abort && (is_master ? div_tick :
        (clk_edge && slave_ok && (state_q == ST_RUN || lead_edge)));

    // bit position within the transfer
    logic [5:0] idx_n;
    logic [5:0] pos;
    logic in_data;
    logic sample_tick;
    logic shift_tick;
    logic in_bit;
    logic done;
    logic load;
    logic start;
    assign idx_n = idx_q + 6'h01;
    assign pos = idx_n - lead;
    assign in_data = tick && idx_n > lead;
    // edge bit set: output moves on trailing edges, input on leading
    assign sample_tick = clock_edge_select ? pos[0] : !pos[0];
    assign shift_tick = clock_edge_select ? !pos[0] :
        ((pos[0] && pos >= 6'h03) || pos == total);
    assign in_bit = (smp_eff || (!clock_edge_select && pos == total)) ?
        din_s : latch_q;
    assign done = in_data && pos == total;
    assign start = state_q == ST_IDLE && is_master && active &&
        transmit_buffer_full_q;
    assign load = state_q == ST_IDLE && active && transmit_buffer_full_q &&
        !tick;

    // transfer state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start || (tick && !is_master))
                    state_d = ST_RUN;
            end
            ST_RUN: begin
                if (done || abort || !port_enable_q)
                    state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            state_q <= ST_IDLE;
        else if (!port_enable_q)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // tick position and divider
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            idx_q <= 6'h00;
            div_q <= 9'h000;
        end else begin
            if (state_d == ST_IDLE)
                idx_q <= 6'h00;
            else if (tick)
                idx_q <= idx_n;
            if (state_q != ST_RUN || div_tick)
                div_q <= 9'h000;
            else if (active)
                div_q <= div_q + 9'h001;
        end
    end

    // shift register: loaded from transmit holding, fed one bit per shift
    logic [15:0] sh_next;
    assign sh_next = {shift_register_q[14:0], in_bit};
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            shift_register_q <= RESET_VALUE;
            latch_q <= 1'b0;
        end else begin
            if (load)
                shift_register_q <= transmit_holding_buffer_q;
            else if (in_data && shift_tick)
                shift_register_q <= sh_next;
            if (in_data && sample_tick && !smp_eff)
                latch_q <= din_s;
        end
    end

    // master clock level: toggles for every tick up to the last bit
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            clk_level_q <= 1'b0;
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= clk_s;
            if (state_q != ST_RUN)
                clk_level_q <= clock_polarity_select;
            else if (tick && idx_n <= 6'(lead + (nbits << 1)))
                clk_level_q <= !clk_level_q;
        end
    end

    // buffer flags and holding registers; hardware set wins over clear
    logic rx_unread;
    logic [15:0] rx_value;
    assign rx_unread = receive_buffer_full_q && !rd_buf;
    assign rx_value = word_width_select ? sh_next : {8'h00, sh_next[7:0]};
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            transmit_holding_buffer_q <= RESET_VALUE;
            receive_holding_buffer_q <= RESET_VALUE;
            transmit_buffer_full_q <= 1'b0;
            receive_buffer_full_q <= 1'b0;
        end else begin
            if (wr_buf) begin
                transmit_holding_buffer_q <= bus_req.wdata;
                transmit_buffer_full_q <= 1'b1;
            end else if (load) begin
                transmit_buffer_full_q <= 1'b0;
            end
            if (done && !rx_unread) begin
                receive_holding_buffer_q <= rx_value;
                receive_buffer_full_q <= 1'b1;
            end else if (rd_buf) begin
                receive_buffer_full_q <= 1'b0;
            end
        end
    end

    // overflow: set by a dropped value, cleared only by software
    logic ovf_set;
    assign ovf_set = done && rx_unread;
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            receive_overflow_flag_q <= 1'b0;
        else if (ovf_set)
            receive_overflow_flag_q <= 1'b1;
        else if (wr_stat && !bus_req.wdata[STAT_RX_OVERFLOW])
            receive_overflow_flag_q <= 1'b0;
    end

    // control registers; the lowest framing bit is not stored
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            port_enable_q <= 1'b0;
            halt_in_idle_q <= 1'b0;
            ctrl_primary_q <= RESET_VALUE;
            ctrl_framing_q <= RESET_VALUE;
        end else begin
            if (wr_stat) begin
                port_enable_q <= bus_req.wdata[STAT_PORT_ENABLE];
                halt_in_idle_q <= bus_req.wdata[STAT_HALT_IN_IDLE];
            end
            if (wr_prim)
                ctrl_primary_q <= bus_req.wdata & PRIMARY_WMASK;
            if (wr_frm)
                ctrl_framing_q <= bus_req.wdata & FRAMING_WMASK;
        end
    end

    // events: sticky, write one to clear, set wins
    logic [EV_COUNT-1:0] ev_set;
    always_comb begin
        ev_set = '0;
        ev_set[EV_RX_DONE] = done && !rx_unread;
        ev_set[EV_TX_TAKEN] = load;
        ev_set[EV_OVERFLOW] = ovf_set;
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ev_status_q <= '0;
            ev_mask_q <= '0;
        end else begin
            if (wr_evs)
                ev_status_q <= (ev_status_q & ~bus_req.wdata[EV_COUNT-1:0]) |
                    ev_set;
            else
                ev_status_q <= ev_status_q | ev_set;
            if (wr_evm)
                ev_mask_q <= bus_req.wdata[EV_COUNT-1:0];
        end
    end
    assign irq = |(ev_status_q & ev_mask_q);

    // read data: valid only in the cycle after the read strobe
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        case (bus_req.addr)
            OFS_STATUS_CONTROL: begin
                rd_mux[STAT_PORT_ENABLE] = port_enable_q;
                rd_mux[STAT_HALT_IN_IDLE] = halt_in_idle_q;
                rd_mux[STAT_RX_OVERFLOW] = receive_overflow_flag_q;
                rd_mux[STAT_TX_FULL] = transmit_buffer_full_q;
                rd_mux[STAT_RX_FULL] = receive_buffer_full_q;
            end
            OFS_CONTROL_PRIMARY: rd_mux = ctrl_primary_q;
            OFS_CONTROL_FRAMING: rd_mux = ctrl_framing_q;
            OFS_DATA_BUFFER: rd_mux = receive_holding_buffer_q;
            OFS_EVENT_STATUS: rd_mux[EV_COUNT-1:0] = ev_status_q;
            OFS_EVENT_MASK: rd_mux[EV_COUNT-1:0] = ev_mask_q;
            default: rd_mux = 16'h0000;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            rd_data_q <= 16'h0000;
        else
            rd_data_q <= bus_req.rd ? rd_mux : 16'h0000;
    end
    assign rd_data = rd_data_q;

    // pin stage: all pin values registered so they line up
    logic selected;
    logic frame_out;
    assign selected = is_master || framed_mode_enable ||
        !slave_select_enable || !sel_s;
    // pulse covers the first bit time of the frame
    assign frame_out = (state_q == ST_RUN && idx_q < FRAME_LEAD_TICKS) ?
        frame_sync_polarity : !frame_sync_polarity;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pins_q <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        end else begin
            pins_q.shift_clock_out <= clk_level_q;
            pins_q.shift_clock_oe_n <= !(port_enable_q && is_master &&
                !internal_clock_disable);
            pins_q.serial_out <= word_width_select ?
                shift_register_q[15] : shift_register_q[7];
            pins_q.serial_out_oe_n <= !(port_enable_q && selected &&
                !data_out_pin_disable);
            pins_q.select_out <= frame_out;
            pins_q.select_oe_n <= !(port_enable_q && gen_frame);
        end
    end
    assign pins = pins_q;

endmodule // spi_serial_port_unit

/* testbench/spi_serial_port_unit_properties.sv */
module spi_props
    import spi_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port, pins and interrupt
    input wire bus_req_t bus_req,
    input wire logic [15:0] rd_data,
    input wire pin_out_t pins,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic en_q, ms_q, fr_q;
    logic [2:0] mask_q;
    // shadow of the control bits that decide which pins may be driven
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            en_q <= 1'b0;
            ms_q <= 1'b0;
            fr_q <= 1'b0;
            mask_q <= '0;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                OFS_STATUS_CONTROL: en_q <= bus_req.wdata[STAT_PORT_ENABLE];
                // master with its own clock enabled
                OFS_CONTROL_PRIMARY: ms_q <= bus_req.wdata[CP_MASTER_ENABLE] &&
                    !bus_req.wdata[CP_INT_CLK_DISABLE];
                // framed with the sync pulse generated here
                OFS_CONTROL_FRAMING: fr_q <= bus_req.wdata[CF_FRAMED_ENABLE] &&
                    !bus_req.wdata[CF_SYNC_DIRECTION];
                OFS_EVENT_MASK: mask_q <= bus_req.wdata[2:0];
                default: ;
            endcase
        end
    end
    property p_idle; !$past(bus_req.rd) |-> rd_data == '0; endproperty
    a_idle: assert property (p_idle) else $error("stray rd_data");
    property p_unmap; $past(bus_req.rd && bus_req.addr > 3'h5) |->
        rd_data == '0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped data");
    property p_off; !en_q && !$past(en_q) |-> &{pins.shift_clock_oe_n,
        pins.serial_out_oe_n, pins.select_oe_n}; endproperty
    a_off: assert property (p_off) else $error("pin driven off");
    property p_slv; !ms_q && !$past(ms_q) |-> pins.shift_clock_oe_n;
    endproperty
    a_slv: assert property (p_slv) else $error("slave drives sck");
    property p_mst; en_q && ms_q && $past(en_q && ms_q) |->
        !pins.shift_clock_oe_n; endproperty
    a_mst: assert property (p_mst) else $error("master sck off");
    property p_frm; !fr_q && !$past(fr_q) |-> pins.select_oe_n; endproperty
    a_frm: assert property (p_frm) else $error("sync driven");
    property p_sync; en_q && fr_q && $past(en_q && fr_q) |->
        !pins.select_oe_n; endproperty
    a_sync: assert property (p_sync) else $error("sync idle");
    property p_irq; mask_q == '0 |-> !irq; endproperty
    a_irq: assert property (p_irq) else $error("irq masked");
    property p_stat; $past(bus_req.rd && bus_req.addr == OFS_STATUS_CONTROL)
        |-> (rd_data & 16'h5FBC) == '0; endproperty
    a_stat: assert property (p_stat) else $error("status spare");
endmodule  // spi_props

/* testbench/spi_far_peer.sv */
module spi_far_peer (
    // link from the port
    input wire logic sck,
    input wire logic mosi,
    // word to send and its length
    input wire logic load,
    input wire logic [15:0] tx_word,
    input wire logic [4:0] n_bits,
    // line back and word caught
    output logic miso,
    output logic [15:0] rx_word
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    logic load_q = 1'b0;
    // a toggle of load restarts; first bit ready before the first edge;
    // catch on the leading edge, msb first, wrapping to resend the word;
    // change on the trailing edge so data never races the sampling edge
    always @(load or sck) begin
        if (load !== load_q) begin
            load_q = load;
            cnt = 0;
            miso = tx_word[n_bits - 1];
        end else if (sck === 1'b1) begin
            rx_word = {rx_word[14:0], mosi};
            cnt = (cnt + 1) % n_bits;
        end else begin
            miso = tx_word[n_bits - 1 - cnt];
        end
    end
endmodule  // spi_far_peer

/* testbench/tb.sv */
module tb
    import spi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, sck_in = 1'b0, mosi = 1'b0;
    logic sel_n = 1'b1, slv = 1'b0, load = 1'b0, rd_q = 1'b0, miso, irq;
    logic [15:0] rd_data, rx_word, w, p, p_tx = '0;
    logic [4:0] p_bits = 5'h08;
    logic [15:0] exp_q [$];
    bus_req_t req = '0;
    pin_out_t pins;
    int n_fail = 0, n_tests = 0, cyc = 0, seed = 88121;
    // data in comes from the peer, or from here in slave mode
    spi_serial_port_unit i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .bus_req(req), .rd_data(rd_data), .shift_clock_pin(sck_in),
        .serial_in_pin(slv ? mosi : miso), .select_pin(sel_n), .pins(pins),
        .core_idle(1'b0), .irq(irq));
    spi_far_peer i_peer (.sck(pins.shift_clock_out), .mosi(pins.serial_out),
        .load(load), .tx_word(p_tx), .n_bits(p_bits), .miso(miso),
        .rx_word(rx_word));
    // 125 MHz system clock
    always #4 ref_clk = ~ref_clk;
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_tests = n_tests + 1;
        if (s !== e) begin
            n_fail = n_fail + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge ref_clk);
    endtask
    task automatic nop(input int n);
        req <= '0;
        repeat (n) @(posedge ref_clk);
    endtask
    // bounded wait; a missing interrupt shows up as a mismatch
    task automatic wait_irq();
        int i;
        req <= '0;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (irq !== 1'b1 && i < 3000);
        chk({15'h0, irq}, 16'h0001);
    endtask
    // link clock of 80 ns, offset from the system clock edges
    task automatic slave_send(input logic s, input logic [15:0] d);
        int i;
        #3 sel_n = s;
        for (i = 15; i >= 0; i--) begin
            mosi = d[i];
            #40 sck_in = 1'b1;
            #40 sck_in = 1'b0;
        end
        #40 sel_n = 1'b1;
        mosi = ~d[0];
        @(posedge ref_clk);
    endtask
    // read answers are checked against the oldest note; hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (rd_q) chk(rd_data, exp_q.pop_front());
        rd_q <= req.rd;
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        for (int a = 0; a < 8; a++) rd(3'(a), RESET_VALUE);
        $display("test 1 done");
        // random control values; never both prescalers 1:1, no bad framing
        w = 16'($random(seed)) & PRIMARY_WMASK & 16'hFFFE;
        p = 16'($random(seed)) & ((w[7] | w[8]) ? 16'h6002 : FRAMING_WMASK);
        wr(OFS_CONTROL_PRIMARY, w);
        wr(OFS_CONTROL_FRAMING, p);
        rd(OFS_CONTROL_PRIMARY, w);
        rd(OFS_CONTROL_FRAMING, p);
        wr(OFS_CONTROL_FRAMING, 16'h0000);
        wr(OFS_CONTROL_PRIMARY, 16'h013D);
        wr(OFS_STATUS_CONTROL, 16'hA000);
        rd(OFS_STATUS_CONTROL, 16'hA000);
        $display("test 2 done");
        // master byte transfer, ratio 16
        p_tx = 16'($random(seed)) & 16'h00FF;
        p = p_tx;
        w = 16'($random(seed)) & 16'h00FF;
        load <= ~load;
        wr(OFS_EVENT_MASK, 16'h0001);
        wr(OFS_DATA_BUFFER, w);
        wait_irq();
        rd(OFS_STATUS_CONTROL, 16'hA001);
        rd(OFS_EVENT_STATUS, 16'h0003);
        wr(OFS_EVENT_STATUS, 16'h0003);
        nop(2);
        chk({15'h0, irq}, 16'h0000);
        chk(rx_word & 16'h00FF, w);
        $display("test 3 done");
        // word transfers back to back while the last value is unread
        p_tx = 16'($random(seed));
        p_bits = 5'h10;
        load <= ~load;
        w = 16'($random(seed));
        wr(OFS_CONTROL_PRIMARY, 16'h053D);
        wr(OFS_EVENT_MASK, 16'h0004);
        wr(OFS_DATA_BUFFER, w ^ 16'h5A5A);
        nop(20);
        chk({15'h0, irq}, 16'h0000);
        wr(OFS_DATA_BUFFER, w);
        rd(OFS_STATUS_CONTROL, 16'hA003);
        wait_irq();
        nop(300);
        rd(OFS_STATUS_CONTROL, 16'hA041);
        rd(OFS_DATA_BUFFER, {8'h00, p[7:0]});
        wr(OFS_STATUS_CONTROL, 16'h8000);
        rd(OFS_STATUS_CONTROL, 16'h8000);
        nop(1);
        chk(rx_word, w);
        $display("test 4 done");
        // slave word: ignored while deselected, taken when selected
        wr(OFS_CONTROL_PRIMARY, 16'h0580);
        wr(OFS_EVENT_STATUS, 16'h0007);
        wr(OFS_EVENT_MASK, 16'h0001);
        nop(1);
        slv = 1'b1;
        w = 16'($random(seed));
        slave_send(1'b1, ~w);
        nop(20);
        chk({15'h0, irq}, 16'h0000);
        slave_send(1'b0, w);
        wait_irq();
        rd(OFS_DATA_BUFFER, w);
        nop(2);
        $display("test 5 done");
        // framed, sync generated here: select pin driven, idles high
        wr(OFS_CONTROL_PRIMARY, 16'h0000);
        wr(OFS_CONTROL_FRAMING, 16'h8000);
        nop(3);
        chk({14'h0, pins.select_oe_n, pins.select_out}, 16'h0001);
        $display("test 6 done");
        end_of_test();
    end
endmodule  // tb

bind spi_serial_port_unit spi_props i_props (.ref_clk(ref_clk),
    .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data), .pins(pins),
    .irq(irq));
